// *** logic/rstint_device.sv ***
`timescale 1ns/1ps
// Functional notes
// - Global reset restores all but soft bit
// - Soft reset bit sticks until zero/pin
// - Reset pin low floats bus outputs
// - Host waits 5 ms after reset
// - Fifty-four writable function reset bits
// - FIFO/voice reset bits also force low power
// - Host reconfigures after low power exit
// - Host follows documented bring-up order
// - Global registers start at address zero
// - Global/intermediate status are real-time summaries
// - Global enable zero blocks that source
// - Mask one blocks the condition
// - Enable one passes latched bit upward
// - Latched bit sets even when disabled
// - Host ANDs status with enable/inverted mask
// - Reading latched register clears all bits
// - No interrupt during any reset
// - Select bit picks float or driven idle
// - Drive select one drives high; reset floats
// - Event during clearing read never lost
module rstint_device (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Processor bus
  rstint_bus_if.device bus,
  // Event sources
  input wire logic [rstint_pkg::UNIT_W-1:0] i_buf_evt,
  input wire logic [rstint_pkg::UNIT_W-1:0] i_agg_evt,
  input wire logic [rstint_pkg::UNIT_W-1:0] i_line_evt,
  // Reset and power outputs
  output logic o_global_reset,
  output logic [rstint_pkg::SRST_N-1:0] o_func_reset,
  output logic [rstint_pkg::LP_N-1:0] o_low_power
);
  import rstint_pkg::*;

  // ----------------------------------------------------------------
  // Reset pin synchroniser and global reset
  // ----------------------------------------------------------------
  logic pin_meta_q;      // First stage, read only by second
  logic pin_low_q;       // Synchronised pin-low level
  logic soft_rst_q;      // Sticky software reset bit
  logic glb_rst;         // Any global reset in effect
  logic drive_sel_q;     // Idle drive select for interrupt pin
  logic [GIS_W-1:0] gie_q;
  logic [SRST_REGS*DATA_W-1:0] srst_q;
  logic [UNIT_W-1:0] buf_lat, buf_mask, agg_lat, agg_en, line_lat, line_en;
  logic buf_sum, agg_sum, line_sum;
  logic [GIS_W-1:0] gis;
  logic int_act;
  data_t rdata_d;

  // Two flops before anyone looks at the pin
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_meta_q <= 1'b1;
      pin_low_q <= 1'b1;
    end else begin
      pin_meta_q <= ~bus.rst_n;
      pin_low_q <= pin_meta_q;
    end
  end

  assign glb_rst = pin_low_q | soft_rst_q;

  // Access decode
  function automatic logic hit(input addr_t a, input addr_t ofs);
    return a == ofs;
  endfunction

  // Keeps only the bits of word r that map onto real function resets
  function automatic data_t word_mask(input int r);
    data_t m;
    m = '0;
    for (int b = 0; b < DATA_W; b++) begin
      m[b] = (r * DATA_W + b) < SRST_N;
    end
    return m;
  endfunction

  logic wr_ok, rd_ok;
  assign wr_ok = bus.wr & ~pin_low_q;
  assign rd_ok = bus.rd & ~pin_low_q;

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Soft bit survives its own reset; only pin or a zero write clears it
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      soft_rst_q <= 1'b0;
    end else if (pin_low_q) begin
      soft_rst_q <= 1'b0;
    end else if (wr_ok && hit(bus.addr, OFS_CTRL)) begin
      soft_rst_q <= bus.wdata[CTRL_SOFT_RST];
    end
  end

  // Drive select defaults to float
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      drive_sel_q <= 1'b0;
    end else if (glb_rst) begin
      drive_sel_q <= 1'b0;
    end else if (wr_ok && hit(bus.addr, OFS_CTRL)) begin
      drive_sel_q <= bus.wdata[CTRL_DRIVE_SEL];
    end
  end

  // Global interrupt enable
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      gie_q <= GIE_RST;
    end else if (glb_rst) begin
      gie_q <= GIE_RST;
    end else if (wr_ok && hit(bus.addr, OFS_GIE)) begin
      gie_q <= bus.wdata[GIS_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Function reset bits
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      srst_q <= '0;
    end else if (glb_rst) begin
      srst_q <= '0;
    end else begin
      for (int r = 0; r < SRST_REGS; r++) begin
        if (wr_ok && hit(bus.addr, addr_t'(OFS_SRST0 + 11'(2 * r)))) begin
          // Bits past the last function reset do not exist and read zero
          srst_q[r*DATA_W +: DATA_W] <= bus.wdata & word_mask(r);
        end
      end
    end
  end

  // Reset levels and low power levels to the function blocks
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_global_reset <= 1'b1;
      o_func_reset <= '0;
      o_low_power <= '1;
    end else begin
      o_global_reset <= glb_rst;
      o_func_reset <= srst_q[SRST_N-1:0];
      // Pin held low keeps the whole device in low power
      o_low_power <= srst_q[LP_N-1:0] | {LP_N{pin_low_q}};
    end
  end

  // ----------------------------------------------------------------
  // Latched status units
  // ----------------------------------------------------------------
  logic [UNIT_W-1:0] evt_gate;
  assign evt_gate = {UNIT_W{~glb_rst}};

  latched_status_unit #(.W(UNIT_W), .MASK_STYLE(1'b1), .GATE_RST(MASK_RST)) u_buf (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_clr_all(glb_rst),
    .i_evt(i_buf_evt & evt_gate),
    .i_rd_clr(rd_ok && hit(bus.addr, OFS_BUF_LAT)),
    .i_gate_wr(wr_ok && hit(bus.addr, OFS_BUF_MASK)),
    .i_gate_data(bus.wdata[UNIT_W-1:0]),
    .o_lat(buf_lat),
    .o_gate(buf_mask),
    .o_summary(buf_sum)
  );

  latched_status_unit #(.W(UNIT_W), .MASK_STYLE(1'b0), .GATE_RST(EN_RST)) u_agg (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_clr_all(glb_rst),
    .i_evt(i_agg_evt & evt_gate),
    .i_rd_clr(rd_ok && hit(bus.addr, OFS_AGG_LAT)),
    .i_gate_wr(wr_ok && hit(bus.addr, OFS_AGG_EN)),
    .i_gate_data(bus.wdata[UNIT_W-1:0]),
    .o_lat(agg_lat),
    .o_gate(agg_en),
    .o_summary(agg_sum)
  );

  latched_status_unit #(.W(UNIT_W), .MASK_STYLE(1'b0), .GATE_RST(EN_RST)) u_line (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_clr_all(glb_rst),
    .i_evt(i_line_evt & evt_gate),
    .i_rd_clr(rd_ok && hit(bus.addr, OFS_LINE_LAT)),
    .i_gate_wr(wr_ok && hit(bus.addr, OFS_LINE_EN)),
    .i_gate_data(bus.wdata[UNIT_W-1:0]),
    .o_lat(line_lat),
    .o_gate(line_en),
    .o_summary(line_sum)
  );

  // Global status, real time, never latched
  always_comb begin
    gis = '0;
    gis[GIS_BUF] = buf_sum;
    gis[GIS_AGG] = agg_sum;
    gis[GIS_LINE] = line_sum;
  end

  assign int_act = |(gis & gie_q) & ~glb_rst;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rdata_d = '0;
    case (bus.addr)
      OFS_CTRL: begin
        rdata_d[CTRL_SOFT_RST] = soft_rst_q;
        rdata_d[CTRL_DRIVE_SEL] = drive_sel_q;
      end
      OFS_GIS: rdata_d[GIS_W-1:0] = gis;
      OFS_GIE: rdata_d[GIS_W-1:0] = gie_q;
      OFS_BUF_LAT: rdata_d[UNIT_W-1:0] = buf_lat;
      OFS_BUF_MASK: rdata_d[UNIT_W-1:0] = buf_mask;
      OFS_AGG_LAT: rdata_d[UNIT_W-1:0] = agg_lat;
      OFS_AGG_EN: rdata_d[UNIT_W-1:0] = agg_en;
      OFS_LINE_LAT: rdata_d[UNIT_W-1:0] = line_lat;
      OFS_LINE_EN: rdata_d[UNIT_W-1:0] = line_en;
      OFS_ID: rdata_d = DEVICE_ID;
      default: begin
        // Function reset words, otherwise zero
        for (int r = 0; r < SRST_REGS; r++) begin
          if (hit(bus.addr, addr_t'(OFS_SRST0 + 11'(2 * r)))) begin
            rdata_d = srst_q[r*DATA_W +: DATA_W];
          end
        end
      end
    endcase
  end

  // Read data captured at the same edge that clears the latch
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      bus.rdata <= '0;
      bus.rdata_oe_n <= 1'b1;
    end else begin
      bus.rdata <= rd_ok ? rdata_d : '0;
      bus.rdata_oe_n <= ~rd_ok;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt pin
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      bus.int_n <= 1'b1;
      bus.int_oe_n <= 1'b1;
    end else begin
      bus.int_n <= ~int_act;
      bus.int_oe_n <= pin_low_q | ~(int_act | drive_sel_q);
    end
  end
endmodule // rstint_device

// *** logic/rstint_pkg.sv ***
package rstint_pkg;
  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 11;
  localparam int DATA_W = 16;
  localparam int UNIT_W = 8;
  localparam int SRST_N = 54;
  localparam int LP_N = 34;
  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [DATA_W-1:0] data_t;
  // ----------------------------------------------------------------
  // Register offsets (global group starts at zero)
  // ----------------------------------------------------------------
  localparam addr_t OFS_CTRL = 11'h000;
  localparam addr_t OFS_GIS = 11'h002;
  localparam addr_t OFS_GIE = 11'h004;
  localparam addr_t OFS_SRST0 = 11'h008;
  localparam addr_t OFS_BUF_LAT = 11'h010;
  localparam addr_t OFS_BUF_MASK = 11'h012;
  localparam addr_t OFS_AGG_LAT = 11'h014;
  localparam addr_t OFS_AGG_EN = 11'h016;
  localparam addr_t OFS_LINE_LAT = 11'h018;
  localparam addr_t OFS_LINE_EN = 11'h01A;
  localparam addr_t OFS_ID = 11'h01E;
  localparam int SRST_REGS = 4;
  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_SOFT_RST = 0;
  localparam int CTRL_DRIVE_SEL = 1;
  localparam int GIS_BUF = 0;
  localparam int GIS_AGG = 1;
  localparam int GIS_LINE = 2;
  localparam int GIS_W = 3;
  localparam logic [GIS_W-1:0] GIE_RST = 3'h0;
  localparam logic [UNIT_W-1:0] MASK_RST = 8'hFF;
  localparam logic [UNIT_W-1:0] EN_RST = 8'h00;
  localparam logic [DATA_W-1:0] DEVICE_ID = 16'h0A5C;  // Arbitrary value
  // Function reset bit layout
  localparam int SR_LINE_RX_FIFO = 0;     // 16 bits
  localparam int SR_AGG_RX_FIFO = 16;     // 16 bits
  localparam int SR_VOICE_RX = 32;
  localparam int SR_VOICE_TX_FIFO = 33;
  localparam int SR_BRIDGE_TABLE = 34;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int RESET_WAIT_MS = 5;
  localparam int RESET_WAIT_CYC = RESET_WAIT_MS * 1000 * CLK_MHZ * 1000 / 1000;
endpackage

// *** logic/rstint_bus_if.sv ***
`timescale 1ns/1ps
interface rstint_bus_if;
  import rstint_pkg::*;
  // Host driven
  addr_t addr;
  data_t wdata;
  logic wr;
  logic rd;
  logic rst_n;
  // Device driven, with enables (low = driving)
  data_t rdata;
  logic rdata_oe_n;
  logic int_n;
  logic int_oe_n;
  // Resolved wires: undriven data reads zero, interrupt line pulled up
  data_t rdata_wire;
  logic int_wire;
  assign rdata_wire = rdata_oe_n ? '0 : rdata;
  assign int_wire = int_oe_n ? 1'b1 : int_n;

  modport device (input addr, wdata, wr, rd, rst_n,
                  output rdata, rdata_oe_n, int_n, int_oe_n);
  modport host (output addr, wdata, wr, rd, rst_n,
                input rdata_wire, int_wire);
endinterface

// *** logic/latched_status_unit.sv ***
`timescale 1ns/1ps
module latched_status_unit #(
  parameter int W = 8,
  parameter bit MASK_STYLE = 1'b0,
  parameter logic [W-1:0] GATE_RST = '0
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_clr_all,
  // Events and host access
  input wire logic [W-1:0] i_evt,
  input wire logic i_rd_clr,
  input wire logic i_gate_wr,
  input wire logic [W-1:0] i_gate_data,
  // State
  output logic [W-1:0] o_lat,
  output logic [W-1:0] o_gate,
  output logic o_summary
);
  import rstint_pkg::*;

  // ----------------------------------------------------------------
  // Latched bits: read clears all, a new event wins over the clear
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_lat <= '0;
    end else if (i_clr_all) begin
      o_lat <= '0;
    end else begin
      o_lat <= (i_rd_clr ? '0 : o_lat) | i_evt;
    end
  end

  // Mask or enable register
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_gate <= GATE_RST;
    end else if (i_clr_all) begin
      o_gate <= GATE_RST;
    end else if (i_gate_wr) begin
      o_gate <= i_gate_data;
    end
  end

  // Real-time summary of the passed bits
  assign o_summary = MASK_STYLE ? |(o_lat & ~o_gate) : |(o_lat & o_gate);
endmodule // latched_status_unit

// *** logic/rstint_host.sv ***
`timescale 1ns/1ps
module rstint_host #(
  parameter int WAIT_CYC = rstint_pkg::RESET_WAIT_CYC
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // User command port
  input wire logic i_reset_req,
  input wire rstint_pkg::addr_t i_addr,
  input wire rstint_pkg::data_t i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output rstint_pkg::data_t o_rdata,
  output logic o_ready,
  output logic o_irq,
  // Device bus
  rstint_bus_if.host bus
);
  import rstint_pkg::*;

  // ----------------------------------------------------------------
  // Reset pin and 5 ms settle wait
  // ----------------------------------------------------------------
  logic [$clog2(WAIT_CYC+1)-1:0] wait_q;
  logic soft_wr;
  logic rd_pend_q;
  logic irq_meta_q;

  // Soft reset write also restarts the wait
  assign soft_wr = i_wr & o_ready & (i_addr == OFS_CTRL) & i_wdata[CTRL_SOFT_RST];

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      bus.rst_n <= 1'b0;
    end else begin
      bus.rst_n <= ~i_reset_req;
    end
  end

  // Settle counter, restarted by any reset condition
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      wait_q <= '0;
      o_ready <= 1'b0;
    end else if (i_reset_req || !bus.rst_n || soft_wr) begin
      wait_q <= '0;
      o_ready <= 1'b0;
    end else if (wait_q == ($clog2(WAIT_CYC+1))'(WAIT_CYC - 1)) begin
      o_ready <= 1'b1;
    end else begin
      wait_q <= wait_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Bus strobes, one cycle behind the user port
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      bus.addr <= '0;
      bus.wdata <= '0;
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      rd_pend_q <= 1'b0;
    end else begin
      bus.addr <= i_addr;
      bus.wdata <= i_wdata;
      bus.wr <= i_wr & o_ready;
      bus.rd <= i_rd & o_ready & ~i_wr;
      rd_pend_q <= bus.rd;
    end
  end

  // Capture device read data when it stands
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= '0;
    end else if (rd_pend_q) begin
      o_rdata <= bus.rdata_wire;
    end
  end

  // Interrupt line through two flops, active high to the user
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_meta_q <= 1'b0;
      o_irq <= 1'b0;
    end else begin
      irq_meta_q <= ~bus.int_wire;
      o_irq <= irq_meta_q;
    end
  end
endmodule // rstint_host

// *** sim/rstint_props.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Bus and interrupt pin checks
// ----------------------------------------------------------------
module rstint_props (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Host driven
  input wire rstint_pkg::addr_t addr,
  input wire rstint_pkg::data_t wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic rst_n,
  // Device driven
  input wire rstint_pkg::data_t rdata,
  input wire logic rdata_oe_n,
  input wire logic int_n,
  input wire logic int_oe_n
);
  import rstint_pkg::*;
  logic soft_q; // Mirror of the soft reset bit
  logic drv_q; // Mirror of the idle drive select bit
  // Follow control writes; pin low clears both, soft reset holds drive select low
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      soft_q <= 1'b0;
      drv_q <= 1'b0;
    end else if (!rst_n) begin
      soft_q <= 1'b0;
      drv_q <= 1'b0;
    end else if (wr && addr == OFS_CTRL) begin
      soft_q <= wdata[CTRL_SOFT_RST];
      drv_q <= wdata[CTRL_DRIVE_SEL] & ~soft_q;
    end else if (soft_q) begin
      drv_q <= 1'b0;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  AST_RD_ANSWER: assert property (rd |=> !rdata_oe_n)
    else $error("read got no answer");
  AST_OE_CAUSE: assert property (!rdata_oe_n |-> $past(rd))
    else $error("data driven without read");
  AST_PIN_FLOAT: assert property ((!rst_n)[*4] |-> rdata_oe_n && int_oe_n)
    else $error("outputs driven while pin low");
  AST_NO_INT_SOFT: assert property (soft_q [*4] |-> int_n)
    else $error("interrupt during soft reset");
  AST_ID_READ: assert property (rd && addr == OFS_ID |=> rdata == DEVICE_ID)
    else $error("identity word wrong");
  AST_UNMAPPED: assert property (rd && addr == 11'h006 |=> rdata == '0)
    else $error("unmapped read not zero");
  AST_SOFT_STICK: assert property (rd && addr == OFS_CTRL |=> rdata[CTRL_SOFT_RST] == soft_q)
    else $error("soft reset bit wrong");
  AST_FLOAT_IDLE: assert property ((rst_n && !drv_q)[*4] ##0 int_n |-> int_oe_n)
    else $error("idle pin driven");
  AST_DRIVEN_IDLE: assert property ((rst_n && drv_q && !soft_q)[*4] |-> !int_oe_n)
    else $error("idle pin not driven");
  AST_INT_DRIVE: assert property (!int_n |-> !int_oe_n)
    else $error("active level not driven");
  // Main scenarios
  cover property (rd ##1 !rdata_oe_n);
  cover property (!int_n);
  cover property ((!rst_n)[*4]);
endmodule // rstint_props

// *** sim/tb.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host and device joined, driven through the host user port
// ----------------------------------------------------------------
module tb;
  import rstint_pkg::*;
  logic clk = 1'b0; // Core clock
  logic rst = 1'b1; // Async reset
  logic req, wr, rd; // Pin reset request and strobes
  addr_t addr;
  data_t wdata, rdata;
  logic ready, irq, grst;
  logic [UNIT_W-1:0] buf_evt, agg_evt, line_evt; // Event pulses
  logic [SRST_N-1:0] frst; // Function resets
  logic [LP_N-1:0] lpwr; // Low power outputs
  int bad_count = 0;
  int n_checks = 0;
  // 125 MHz clock
  always #4 clk = ~clk;
  rstint_bus_if rstint_bus_if_i ();
  rstint_device rstint_device_i (.i_core_clk(clk), .i_rst(rst), .bus(rstint_bus_if_i.device),
    .i_buf_evt(buf_evt), .i_agg_evt(agg_evt), .i_line_evt(line_evt),
    .o_global_reset(grst), .o_func_reset(frst), .o_low_power(lpwr));
  rstint_host #(.WAIT_CYC(20)) rstint_host_i (.i_core_clk(clk), .i_rst(rst),
    .i_reset_req(req), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .o_ready(ready), .o_irq(irq), .bus(rstint_bus_if_i.host));
  rstint_props rstint_props_i (.i_core_clk(clk), .i_rst(rst), .addr(rstint_bus_if_i.addr),
    .wdata(rstint_bus_if_i.wdata), .wr(rstint_bus_if_i.wr), .rd(rstint_bus_if_i.rd),
    .rst_n(rstint_bus_if_i.rst_n), .rdata(rstint_bus_if_i.rdata),
    .rdata_oe_n(rstint_bus_if_i.rdata_oe_n), .int_n(rstint_bus_if_i.int_n),
    .int_oe_n(rstint_bus_if_i.int_oe_n));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input addr_t a, input data_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read lands in o_rdata three edges after the strobe
  task automatic rd_chk(input addr_t a, input data_t exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk(64'(rdata), 64'(exp));
  endtask
  // Settle wait after any reset, bounded
  task automatic wait_ready();
    repeat (4) @(posedge clk);
    #1;
    for (int k = 0; k < 100 && ready !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    chk(64'(ready), 64'h1);
  endtask
  // One-cycle event on unit 0 buffer, 1 aggregation, 2 line
  task automatic pulse(input int s, input logic [7:0] v);
    @(posedge clk);
    if (s == 0) buf_evt <= v;
    else if (s == 1) agg_evt <= v;
    else line_evt <= v;
    @(posedge clk);
    buf_evt <= '0;
    agg_evt <= '0;
    line_evt <= '0;
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic results();
    if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    results();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {req, wr, rd, addr, wdata, buf_evt, agg_evt, line_evt} = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    wait_ready();
    rd_chk(OFS_ID, DEVICE_ID);
    rd_chk(OFS_GIE, 16'(GIE_RST));
    rd_chk(OFS_BUF_MASK, 16'(MASK_RST));
    rd_chk(OFS_AGG_EN, 16'(EN_RST));
    rd_chk(11'h006, 16'h0000);
    chk(64'(rstint_bus_if_i.int_oe_n), 64'h1);
    // Disabled event latches anyway, read clears all
    pulse(1, 8'h05);
    chk(64'(irq), 64'h0);
    rd_chk(OFS_AGG_LAT, 16'h0005);
    rd_chk(OFS_AGG_LAT, 16'h0000);
    // Enabled aggregation source, global enable written last
    wr_reg(OFS_AGG_EN, 16'h0001);
    wr_reg(OFS_GIE, 16'h0002);
    pulse(1, 8'h03);
    chk(64'(irq), 64'h1);
    rd_chk(OFS_GIS, 16'h0002);
    wr_reg(OFS_GIE, 16'h0000);
    repeat (6) @(posedge clk);
    #1 chk(64'(irq), 64'h0);
    rd_chk(OFS_AGG_LAT, 16'h0003);
    // Service only the latched bits that the enable passes
    chk(64'(rdata & 16'h0001), 64'h1);
    rd_chk(OFS_GIS, 16'h0000);
    // Mask style buffer unit and enable style line unit
    pulse(0, 8'h09);
    rd_chk(OFS_GIS, 16'h0000);
    rd_chk(OFS_BUF_LAT, 16'h0009);
    wr_reg(OFS_BUF_MASK, 16'h00FE);
    wr_reg(OFS_GIE, 16'h0007);
    pulse(0, 8'h01);
    chk(64'(irq), 64'h1);
    wr_reg(OFS_LINE_EN, 16'h0080);
    pulse(2, 8'h80);
    rd_chk(OFS_GIS, 16'h0005);
    rd_chk(OFS_BUF_LAT, 16'h0001);
    rd_chk(OFS_LINE_LAT, 16'h0080);
    repeat (6) @(posedge clk);
    #1 chk(64'(irq), 64'h0);
    // Event arriving on the clearing edge survives
    pulse(2, 8'h02);
    @(posedge clk);
    addr <= OFS_LINE_LAT;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    line_evt <= 8'h40;
    @(posedge clk);
    line_evt <= 8'h00;
    repeat (2) @(posedge clk);
    #1 chk(64'(rdata), 64'h2);
    rd_chk(OFS_LINE_LAT, 16'h0040);
    // Idle pin driven high when selected
    wr_reg(OFS_CTRL, 16'h0002);
    repeat (4) @(posedge clk);
    #1 chk(64'({rstint_bus_if_i.int_oe_n, rstint_bus_if_i.int_wire}), 64'h1);
    pulse(2, 8'h80);
    chk(64'(irq), 64'h1);
    // Soft reset with an interrupt pending; other writes are refused meanwhile
    wr_reg(OFS_CTRL, 16'h0001);
    wait_ready();
    chk(64'({grst, irq}), 64'h2);
    rd_chk(OFS_CTRL, 16'h0001);
    wr_reg(OFS_GIE, 16'h0007);
    rd_chk(OFS_GIE, 16'h0000);
    rd_chk(OFS_LINE_LAT, 16'h0000);
    wr_reg(OFS_CTRL, 16'h0000);
    wait_ready();
    chk(64'(grst), 64'h0);
    // Function resets and their low power side effect
    for (int k = 0; k < SRST_REGS; k++) wr_reg(OFS_SRST0 + addr_t'(2 * k), 16'hFFFF);
    repeat (3) @(posedge clk);
    #1 chk(64'(frst), 64'h003F_FFFF_FFFF_FFFF);
    chk(64'(lpwr), 64'h3_FFFF_FFFF);
    rd_chk(OFS_SRST0 + 11'h006, 16'h003F);
    for (int k = 0; k < SRST_REGS; k++) wr_reg(OFS_SRST0 + addr_t'(2 * k), 16'h0000);
    wr_reg(OFS_SRST0 + 11'h004, 16'h0004);
    repeat (3) @(posedge clk);
    #1 chk(64'(frst), 64'h4_0000_0000);
    chk(64'(lpwr), 64'h0);
    // Pin reset floats the bus and clears the soft bit
    wr_reg(OFS_CTRL, 16'h0001);
    req <= 1'b1;
    repeat (8) @(posedge clk);
    #1 chk(64'({rstint_bus_if_i.rdata_oe_n, rstint_bus_if_i.int_oe_n, grst}), 64'h7);
    chk(64'(lpwr), 64'h3_FFFF_FFFF);
    req <= 1'b0;
    // Leaving low power: wait, then everything starts from defaults again
    wait_ready();
    rd_chk(OFS_CTRL, 16'h0000);
    chk(64'(frst), 64'h0);
    rd_chk(OFS_LINE_EN, 16'(EN_RST));
    results();
  end
endmodule // tb
